/* hdl/srst_pkg.sv */
// Constants and types of the system reset controller
package srst_pkg;

  // ==========================================
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CLK_NS  = 4;
  // Least low time for a brown-out
  localparam int BOD_T_NS = 2000;
  localparam int BOD_CYC  = (BOD_T_NS + CLK_NS - 1) / CLK_NS;
  localparam int BOD_W    = $clog2(BOD_CYC + 1);
  // Delay counter width
  localparam int DLY_W = 24;

  // ==========================================
  // Register map
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h01;
  localparam int POR_BIT  = 0;
  localparam int PIN_BIT  = 1;
  localparam int BOD_BIT  = 2;
  localparam int WDT_BIT  = 3;
  localparam int SCAN_BIT = 4;
  localparam int SDIS_BIT = 7;

  // ==========================================
  // Pin synchronisers
  localparam int SYNC_N = 3;
  localparam int IN_PIN = 0;
  localparam int IN_POR = 1;
  localparam int IN_BOD = 2;

  // Reset sources, active high
  typedef struct packed {
    logic scan;
    logic wdt;
    logic brownout_detect;
    logic pin;
    logic por;
  } srst_src_t;

  // Reset sequence states
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_RUN
  } srst_state_t;

endpackage

/* hdl/srst_ctrl.sv */
// System reset controller: sources, delay counter, cause flags, APB
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Reset loads I/O state; release starts fetch
// - Pin and power-on force I/O asynchronously
// - Fuse-selected delay stretches reset after sources
// - Five sources, any one asserts reset
// - Long low on pin resets without clock
// - Pin release leaves reset after timeout
// - Power-on releases via delay, reasserts at once
// - Enabled brown-out asserts, releases via delay
// - Brown-out needs two microseconds below level
// - Enabled watchdog expiry issues a reset
// - Watchdog pulse one cycle; delay follows it
// - Scan reset bit holds reset while set
// - Scan flag bit 4; cleared by power-on, zero
// - Watchdog flag bit 3; power-on or zero
// - Brown-out flag bit 2; power-on or zero
// - Pin flag bit 1; power-on or zero
// - Power-on flag bit 0; only zero clears
// - Debug fuse keeps clock in deep sleep while scan interface is on
// - Disable bit or fuse disables scan interface
module srst_ctrl
  import srst_pkg::*;
#(
  parameter int P_TOUT0_US = 1,
  parameter int P_TOUT1_US = 4,
  parameter int P_TOUT2_US = 16,
  parameter int P_TOUT3_US = 64
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_por_low,
  input  wire logic        i_bod_low,
  input  wire logic        i_wdt_expire,
  input  wire logic        i_wdt_enable,
  input  wire logic        i_scan_reset_bit,
  input  wire logic        i_brownout_enable_fuse,
  input  wire logic [1:0]  i_clock_select_fuses,
  input  wire logic        i_debug_enable_fuse,
  input  wire logic        i_scan_if_enable_fuse,
  input  wire logic        i_deep_sleep,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic             o_core_reset_n,
  output logic             o_io_reset_n,
  output logic             o_fetch_start,
  output logic             o_scan_if_enable,
  output logic             o_main_clk_keep
);

  // ==========================================
  // Delay selection

  // Timeout lengths in cycles
  localparam int TOUT0_CYC = P_TOUT0_US * CLK_MHZ;
  localparam int TOUT1_CYC = P_TOUT1_US * CLK_MHZ;
  localparam int TOUT2_CYC = P_TOUT2_US * CLK_MHZ;
  localparam int TOUT3_CYC = P_TOUT3_US * CLK_MHZ;
  localparam int TOUT_MAX  = 2 ** DLY_W;

  // Refuse timeouts the counter cannot hold
  if (P_TOUT0_US < 1 || TOUT0_CYC >= TOUT_MAX ||
      P_TOUT1_US < 1 || TOUT1_CYC >= TOUT_MAX ||
      P_TOUT2_US < 1 || TOUT2_CYC >= TOUT_MAX ||
      P_TOUT3_US < 1 || TOUT3_CYC >= TOUT_MAX) begin : g_bad_tout
    $error("srst_ctrl: timeout out of range");
  end

  logic [DLY_W-1:0] tout_sel;  // Selected length

  // Fuses are static, so no synchroniser
  always_comb begin
    case (i_clock_select_fuses)
      2'h0:    tout_sel = DLY_W'(TOUT0_CYC);
      2'h1:    tout_sel = DLY_W'(TOUT1_CYC);
      2'h2:    tout_sel = DLY_W'(TOUT2_CYC);
      default: tout_sel = DLY_W'(TOUT3_CYC);
    endcase
  end

  // ==========================================
  // Asynchronous reset net

  logic rst_all_n;  // Block reset, pin or supply

  // Pin and supply act with no clock at all
  assign rst_all_n = i_reset_n & i_reset_pin_n & ~i_por_low;

  // ==========================================
  // Pin synchronisers

  logic [SYNC_N-1:0] async_in;  // Raw, active high
  logic [SYNC_N-1:0] stab_r;    // Agreed levels

  assign async_in[IN_PIN] = ~i_reset_pin_n;
  assign async_in[IN_POR] = i_por_low;
  assign async_in[IN_BOD] = i_bod_low;

  // Three flops; a change counts once two agree
  for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
    logic [2:0] s_r;     // Stage 0 feeds stage 1 only
    logic       stab_g;  // Agreed level of this input
    // One process per input, so each bit has one driver
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        s_r    <= 3'h0;
        stab_g <= 1'b0;
      end else begin
        s_r <= {s_r[1:0], async_in[g]};
        // Second and third stage agree
        if (s_r[1] == s_r[2]) begin
          stab_g <= s_r[2];
        end
      end
    end
    assign stab_r[g] = stab_g;
  end

  // ==========================================
  // Brown-out filter

  logic [BOD_W-1:0] bod_cnt_r;  // Cycles below level
  logic             bod_act_r;  // Brown-out reset

  // Short dips are ignored by the counter
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bod_cnt_r <= '0;
      bod_act_r <= 1'b0;
    end else if (!i_brownout_enable_fuse || !stab_r[IN_BOD]) begin
      // Disabled, or back above upper level
      bod_cnt_r <= '0;
      bod_act_r <= 1'b0;
    end else if (bod_cnt_r == BOD_W'(BOD_CYC - 1)) begin
      // Low long enough
      bod_act_r <= 1'b1;
    end else begin
      bod_cnt_r <= bod_cnt_r + 1'b1;
    end
  end

  // ==========================================
  // Watchdog pulse

  logic wd_pulse_r;  // One-cycle watchdog reset

  // Never longer than one cycle, even if held
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wd_pulse_r <= 1'b0;
    end else begin
      wd_pulse_r <= i_wdt_expire & i_wdt_enable & ~wd_pulse_r;
    end
  end

  // ==========================================
  // Source collection

  srst_src_t src;      // All five sources
  logic      any_src;  // Any source active

  assign src.por  = stab_r[IN_POR];
  assign src.pin  = stab_r[IN_PIN];
  assign src.brownout_detect  = bod_act_r;
  assign src.wdt  = wd_pulse_r;
  assign src.scan = i_scan_reset_bit;
  assign any_src  = |src;

  // ==========================================
  // Reset sequencer

  srst_state_t      state_r;    // Sequence state
  srst_state_t      state_nxt;  // Next state
  logic [DLY_W-1:0] dly_cnt_r;  // Delay counter

  // Any source returns to hold at once
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        // Last source gone: stretch
        if (!any_src) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (any_src) begin
          state_nxt = ST_HOLD;
        end else if (dly_cnt_r == '0) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          state_nxt = ST_HOLD;
        end
      end
      default: state_nxt = ST_HOLD;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Loaded in hold, counts down in delay
  always_ff @(posedge i_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      dly_cnt_r <= '0;
    end else if (state_r != ST_DELAY) begin
      dly_cnt_r <= tout_sel - 1'b1;
    end else if (dly_cnt_r != '0) begin
      dly_cnt_r <= dly_cnt_r - 1'b1;
    end
  end

  // Reset outputs come from flops with async clear
  always_ff @(posedge i_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      o_core_reset_n <= 1'b0;
      o_io_reset_n   <= 1'b0;
      o_fetch_start  <= 1'b0;
    end else begin
      o_core_reset_n <= (state_nxt == ST_RUN);
      o_io_reset_n   <= (state_nxt == ST_RUN);
      // Fetch from reset vector on release
      o_fetch_start  <= (state_nxt == ST_RUN) && (state_r != ST_RUN);
    end
  end

  // ==========================================
  // APB slave

  logic       hit;     // Address is mapped
  logic       wr_stat; // Write completes now
  logic [7:0] stat_r;  // Cause flags and disable

  assign hit     = (i_paddr == STATUS_OFS);
  assign wr_stat = i_psel & i_penable & o_pready & i_pwrite & hit;

  // One wait-free access phase after setup
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      // Capture answer in the setup cycle
      if (i_psel && !i_penable) begin
        o_prdata  <= hit ? {24'h00_0000, stat_r} : 32'h0000_0000;
        o_pslverr <= ~hit;
      end
    end
  end

  // ==========================================
  // Cause flags

  logic [7:0] stat_nxt;  // Next flag value

  // Order: write, power-on clear, sets last
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      // Zero clears a flag, one leaves it
      stat_nxt[4:0]     = stat_r[4:0] & i_pwdata[4:0];
      stat_nxt[SDIS_BIT] = i_pwdata[SDIS_BIT];
    end
    if (src.por) begin
      // Power-on clears all other causes
      stat_nxt[4:1] = 4'h0;
    end
    if (!o_core_reset_n) begin
      // Disable bit is an I/O register
      stat_nxt[SDIS_BIT] = 1'b0;
    end
    // A set wins over any clear
    stat_nxt[POR_BIT]  = stat_nxt[POR_BIT] | src.por;
    stat_nxt[PIN_BIT]  = stat_nxt[PIN_BIT] | src.pin;
    stat_nxt[BOD_BIT]  = stat_nxt[BOD_BIT] | src.brownout_detect;
    stat_nxt[WDT_BIT]  = stat_nxt[WDT_BIT] | src.wdt;
    stat_nxt[SCAN_BIT] = stat_nxt[SCAN_BIT] | src.scan;
    stat_nxt[6:5]      = 2'h0;
  end

  // Flags survive every reset but the block's own; power-on keeps only its own flag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_r <= STATUS_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ==========================================
  // Debug and clock keeping

  // Debug needs the interface, so either off saves power
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_scan_if_enable <= 1'b0;
      o_main_clk_keep  <= 1'b0;
    end else begin
      o_scan_if_enable <= i_scan_if_enable_fuse & ~stat_r[SDIS_BIT];
      o_main_clk_keep  <= i_debug_enable_fuse & i_scan_if_enable_fuse &
                          ~stat_r[SDIS_BIT] & i_deep_sleep;
    end
  end

  // ==========================================
  // Assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_src_holds: assert property (any_src |=> !o_core_reset_n)
    else $error("source did not hold reset");

  a_scan_holds: assert property (i_scan_reset_bit [*2] |-> !o_core_reset_n)
    else $error("scan bit did not hold reset");

  a_delay_holds: assert property (state_r == ST_DELAY && dly_cnt_r != '0
    |=> !o_core_reset_n)
    else $error("left reset before timeout");

  a_release_via: assert property ($rose(o_core_reset_n)
    |-> $past(state_r == ST_DELAY) && $past(dly_cnt_r) == '0)
    else $error("release skipped delay");

  a_io_async: assert property (!rst_all_n |-> !o_io_reset_n)
    else $error("I/O not forced");

  a_wd_pulse: assert property (wd_pulse_r |=> !wd_pulse_r)
    else $error("watchdog pulse too long");

  a_wd_cause: assert property ($rose(wd_pulse_r)
    |-> $past(i_wdt_expire) && $past(i_wdt_enable))
    else $error("watchdog pulse without cause");

  a_bod_filter: assert property ($rose(bod_act_r)
    |-> $past(bod_cnt_r) == BOD_W'(BOD_CYC - 1) && $past(i_brownout_enable_fuse))
    else $error("brown-out not filtered");

  a_flag_wdt: assert property (wd_pulse_r |=> stat_r[WDT_BIT])
    else $error("watchdog flag not set");

  a_flag_pin: assert property (src.pin |=> stat_r[PIN_BIT])
    else $error("pin flag not set");

  a_flag_scan: assert property (src.scan |=> stat_r[SCAN_BIT])
    else $error("scan flag not set");

  a_flag_bod: assert property (src.brownout_detect |=> stat_r[BOD_BIT])
    else $error("brown-out flag not set");

  a_por_keeps: assert property (stat_r[POR_BIT] && !wr_stat |=> stat_r[POR_BIT])
    else $error("power-on flag lost");

  a_if_off: assert property (i_scan_if_enable_fuse == 1'b0 ##1 1'b1
    |-> !o_scan_if_enable && !o_main_clk_keep)
    else $error("scan interface not disabled");

  a_clk_keep: assert property (i_debug_enable_fuse && i_scan_if_enable_fuse && !stat_r[SDIS_BIT] && i_deep_sleep
    && $stable(i_debug_enable_fuse) |=> o_main_clk_keep)
    else $error("main clock not kept");

  a_fetch: assert property (o_fetch_start |-> o_core_reset_n && !$past(o_core_reset_n))
    else $error("fetch not at release");

  c_wd_reset: cover property ($rose(wd_pulse_r) ##[1:300] $rose(o_fetch_start));
  c_bod_reset: cover property ($rose(bod_act_r) ##[1:50] $fell(bod_act_r));
  c_release: cover property ($rose(o_core_reset_n));
  c_clear: cover property (wr_stat && !i_pwdata[POR_BIT] && stat_r[POR_BIT]);

endmodule

/* verification/srst_src_model.sv */
// Model of the reset sources that surround the controller
`timescale 1ns/1ps
module srst_src_model (
  input  wire logic i_clk,
  output logic      o_reset_pin_n,
  output logic      o_por_low,
  output logic      o_bod_low,
  output logic      o_wdt_expire,
  output logic      o_scan_reset_bit
);
  // ==========================================
  // Idle levels: pin high, supply good
  initial begin
    o_reset_pin_n    = 1'b1;
    o_por_low        = 1'b0;
    o_bod_low        = 1'b0;
    o_wdt_expire     = 1'b0;
    o_scan_reset_bit = 1'b0;
  end

  // ==========================================
  // One source active for n cycles: 0 pin, 1 power, 2 brown-out, 3 watchdog, 4 scan
  task automatic drive(input int src, input int n);
    @(posedge i_clk);
    case (src)
      0: o_reset_pin_n <= 1'b0;
      1: o_por_low <= 1'b1;
      2: o_bod_low <= 1'b1;
      3: o_wdt_expire <= 1'b1;
      default: o_scan_reset_bit <= 1'b1;
    endcase
    repeat (n) @(posedge i_clk);
    // Release all together; a watchdog call with n of 1 is a one-cycle pulse
    o_reset_pin_n    <= 1'b1;
    o_por_low        <= 1'b0;
    o_bod_low        <= 1'b0;
    o_wdt_expire     <= 1'b0;
    o_scan_reset_bit <= 1'b0;
  endtask
endmodule

/* verification/srst_ctrl_tb_top.sv */
// Self-checking testbench of the system reset controller
`timescale 1ns/1ps
module srst_ctrl_tb_top;
  import srst_pkg::*;
  // ==========================================
  // Signals and counters
  localparam int T = 250;  // Delay cycles with one microsecond selected
  logic        i_clk, i_reset_n, pin_n, por_low, bod_low, wdt_exp, scan_bit;
  logic        wdt_en, bod_fuse, dbg_fuse, scan_fuse, sleep;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        core_n, io_n, fetch, scan_en, clk_keep, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;

  srst_ctrl #(.P_TOUT0_US(1)) srst_ctrl_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reset_pin_n(pin_n), .i_por_low(por_low),
    .i_bod_low(bod_low), .i_wdt_expire(wdt_exp), .i_wdt_enable(wdt_en),
    .i_scan_reset_bit(scan_bit), .i_brownout_enable_fuse(bod_fuse),
    .i_clock_select_fuses(2'b00), .i_debug_enable_fuse(dbg_fuse),
    .i_scan_if_enable_fuse(scan_fuse), .i_deep_sleep(sleep), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_core_reset_n(core_n),
    .o_io_reset_n(io_n), .o_fetch_start(fetch), .o_scan_if_enable(scan_en),
    .o_main_clk_keep(clk_keep));

  srst_src_model srst_src_model_i (
    .i_clk(i_clk), .o_reset_pin_n(pin_n), .o_por_low(por_low), .o_bod_low(bod_low),
    .o_wdt_expire(wdt_exp), .o_scan_reset_bit(scan_bit));

  // ==========================================
  // Clock, and a cycle ceiling so a hang still ends in a verdict
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdstat(input logic [31:0] exp);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("status", exp, rd);
  endtask
  // Counts edges until core reset lifts; fetch pulse must come with it
  task automatic wait_up();
    n = 0;
    do begin @(posedge i_clk); #1; n++; end while (core_n !== 1'b1);
    chk("fetch start", 1, fetch);
    @(posedge i_clk); #1;
    chk("fetch end", 0, fetch);
  endtask
  // Source that must clear I/O state without waiting for a clock edge
  task automatic async_src(input int src, input int len);
    fork
      srst_src_model_i.drive(src, len);
      begin @(posedge i_clk); #1; chk("io async", 0, io_n); end
    join
    wait_up();
    chk("delay run", 1, n > T);
  endtask
  // Brown-out dip; a long enabled dip must still hold reset at its end
  task automatic bod_try(input logic f, input int len, input logic exp_core);
    bod_fuse <= f;
    srst_src_model_i.drive(2, len);
    chk("bod core", exp_core, core_n);
    if (exp_core === 1'b0) wait_up();
  endtask

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {wdt_en, bod_fuse, dbg_fuse, sleep} = '0;
    scan_fuse = 1'b1;
    i_reset_n = 1'b0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    wait_up();
    rdstat(32'h0000_0001);
    apb(1'b1, STATUS_OFS, 32'h0000_0000);
    rdstat(32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("unmapped err", 1, err);
    // Ones never set a flag; top bit turns the scan interface off
    apb(1'b1, STATUS_OFS, 32'h0000_00FF);
    rdstat(32'h0000_0080);
    chk("scan if off", 0, scan_en);
    apb(1'b1, STATUS_OFS, 32'h0000_0000);
    dbg_fuse <= 1'b1;
    sleep <= 1'b1;
    repeat (3) @(posedge i_clk); #1;
    chk("scan if on", 1, scan_en);
    chk("clock kept", 1, clk_keep);
    dbg_fuse <= 1'b0;
    scan_fuse <= 1'b0;
    repeat (3) @(posedge i_clk); #1;
    chk("clock free", 0, clk_keep);
    chk("fuse off", 0, scan_en);
    sleep <= 1'b0;
    scan_fuse <= 1'b1;
    // Watchdog pulse: low from the second edge on, one delay after the pulse
    wdt_en <= 1'b1;
    srst_src_model_i.drive(3, 1);
    wait_up();
    chk("wdt delay", T + 2, n);
    rdstat(32'h0000_0008);
    wdt_en <= 1'b0;
    srst_src_model_i.drive(3, 1);
    repeat (20) @(posedge i_clk); #1;
    chk("wdt disabled", 1, core_n);
    async_src(0, 10);
    rdstat(32'h0000_000A);
    bod_try(1'b0, 600, 1'b1);
    bod_try(1'b1, 100, 1'b1);
    bod_try(1'b1, 600, 1'b0);
    rdstat(32'h0000_000E);
    // Scan bit held past a whole delay keeps reset low throughout
    srst_src_model_i.drive(4, 300);
    chk("scan hold", 0, core_n);
    wait_up();
    rdstat(32'h0000_001E);
    async_src(1, 5);
    rdstat(32'h0000_0001);
    end_of_test();
  end
endmodule
